// *** at_timer_pkg.sv ***
// package: register map, field positions, reset values and timing counts
// assumes: one 250 MHz clock, byte registers in 32-bit AHB-Lite words
package at_timer_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_TIMER_CONTROL_STATUS = 8'h0d;
    localparam logic [7:0] IDX_COUNTER_HIGH = 8'h0e;
    localparam logic [7:0] IDX_COUNTER_LOW = 8'h0f;
    localparam logic [7:0] IDX_RELOAD_HIGH = 8'h10;
    localparam logic [7:0] IDX_RELOAD_LOW = 8'h11;
    localparam logic [7:0] IDX_PWM_OUTPUT_CONTROL = 8'h12;
    localparam logic [7:0] IDX_PWM_CHANNEL_STATUS = 8'h13;
    localparam logic [7:0] IDX_DUTY_COMPARE_HIGH = 8'h17;
    localparam logic [7:0] IDX_DUTY_COMPARE_LOW = 8'h18;
    // power mode inputs gathered into one register
    localparam logic [7:0] IDX_POWER_MODE = 8'h1c;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CSR_CLOCK_SELECT_HI = 4;
    localparam int CSR_CLOCK_SELECT_LO = 3;
    localparam int CSR_OVERFLOW_FLAG = 2;
    localparam int CSR_OVERFLOW_IRQ_ENABLE = 1;
    localparam int CSR_COMPARE_IRQ_ENABLE = 0;
    localparam int PWM_OUTPUT_CONTROL_PIN_ENABLE = 0;
    localparam int CHS_OUTPUT_POLARITY = 1;
    localparam int CHS_COMPARE_FLAG = 0;
    localparam int PM_SLOW = 0;
    localparam int PM_WAIT = 1;
    localparam int PM_ACTIVE_HALT = 2;
    localparam int PM_HALT = 3;

    // ------------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [11:0] COUNT_RESET = 12'h000;
    localparam logic [11:0] COUNT_TOP = 12'hfff;
    localparam logic [1:0] CLK_OFF = 2'b00;
    localparam logic [1:0] CLK_LITE = 2'b01;
    localparam logic [1:0] CLK_CPU = 2'b10;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int SLOW_DIVIDE = 32;
    localparam int CLOCK_MHZ = 250;
    localparam int LITE_TICK_MS = 1;
    localparam int LITE_TICK_CYCLES = LITE_TICK_MS * CLOCK_MHZ * 1000;

endpackage : at_timer_pkg

// *** at_tick_divider.sv ***
// tick divider: one-cycle pulse every DIVIDE qualified input pulses
// assumes: single clock, input pulses already one cycle wide
`timescale 1ns/1ps
module at_tick_divider #(
    parameter int DIVIDE = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick_in,
    output logic tick_out
);
    localparam int CW = $clog2(DIVIDE);
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    logic [CW-1:0] count;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (tick_in) begin
            count <= (count == LAST) ? '0 : count + 1'b1;
        end
    end

    assign tick_out = tick_in && (count == LAST);
endmodule // at_tick_divider

// *** at_lite_tick.sv ***
// lite-timer stand-in: 1 ms tick at the cpu clock rate, counting only while run is high
// assumes: period given in clock cycles, shortened for simulation
`timescale 1ns/1ps
module at_lite_tick #(
    parameter int PERIOD = 250000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    output logic tick
);
    logic [31:0] count;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (run) begin
            count <= (count == 32'(PERIOD - 1)) ? '0 : count + 32'h1;
        end
    end

    assign tick = run && (count == 32'(PERIOD - 1));
endmodule // at_lite_tick

// *** autoreload_timer_pwm_compare.sv ***
// 12-bit autoreload timer with one pwm / output-compare channel
// assumes: sole AHB-Lite slave, power mode bits written by software
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module autoreload_timer_pwm_compare
    import at_timer_pkg::*;
#(
    parameter int LITE_PERIOD = at_timer_pkg::LITE_TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic pwm_output_pin,
    output logic pwm_pin_oe,
    output logic overflow_irq,
    output logic compare_irq,
    output logic wake_request
);
    import at_timer_pkg::*;

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic rd_now;

    function automatic logic [7:0] word_index(input logic [31:0] a);
        word_index = a[9:2];
    endfunction

    assign rd_now = hsel && hready && htrans[1] && !hwrite;
    assign rd_idx = word_index(haddr);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
        end else begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            wr_idx <= word_index(haddr);
        end
    end

    function automatic logic wr_to(input logic [7:0] idx, input logic p,
                                   input logic [7:0] w);
        wr_to = p && (w == idx);
    endfunction

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [1:0] clock_select;
    logic overflow_irq_enable;
    logic compare_irq_enable;
    logic pwm_pin_enable;
    logic output_polarity;
    logic [11:0] reload_value;
    logic [11:0] duty_compare_value;
    logic [11:0] shadow;
    logic compare_locked;
    logic [3:0] power_mode;
    logic [7:0] wb;

    assign wb = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_select <= CLK_OFF;
            overflow_irq_enable <= 1'b0;
            compare_irq_enable <= 1'b0;
        end else if (wr_to(IDX_TIMER_CONTROL_STATUS, wr_pend, wr_idx)) begin
            clock_select <= {wb[CSR_CLOCK_SELECT_HI], wb[CSR_CLOCK_SELECT_LO]};
            overflow_irq_enable <= wb[CSR_OVERFLOW_IRQ_ENABLE];
            compare_irq_enable <= wb[CSR_COMPARE_IRQ_ENABLE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_pin_enable <= 1'b0;
            output_polarity <= 1'b0;
            power_mode <= 4'h0;
        end else begin
            if (wr_to(IDX_PWM_OUTPUT_CONTROL, wr_pend, wr_idx)) begin
                pwm_pin_enable <= wb[PWM_OUTPUT_CONTROL_PIN_ENABLE];
            end
            if (wr_to(IDX_PWM_CHANNEL_STATUS, wr_pend, wr_idx)) begin
                output_polarity <= wb[CHS_OUTPUT_POLARITY];
            end
            if (wr_to(IDX_POWER_MODE, wr_pend, wr_idx)) begin
                power_mode <= wb[3:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_value <= COUNT_RESET;
        end else if (wr_to(IDX_RELOAD_HIGH, wr_pend, wr_idx)) begin
            reload_value[11:8] <= wb[3:0];
        end else if (wr_to(IDX_RELOAD_LOW, wr_pend, wr_idx)) begin
            reload_value[7:0] <= wb;
        end
    end

    // high write locks compare, low write unlocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            duty_compare_value <= COUNT_RESET;
            compare_locked <= 1'b0;
        end else if (wr_to(IDX_DUTY_COMPARE_HIGH, wr_pend, wr_idx)) begin
            duty_compare_value[11:8] <= wb[3:0];
            compare_locked <= 1'b1;
        end else if (wr_to(IDX_DUTY_COMPARE_LOW, wr_pend, wr_idx)) begin
            duty_compare_value[7:0] <= wb;
            compare_locked <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // counter clock
    // ------------------------------------------------------------------
    logic lite_tick;
    logic halted;
    logic src_tick;
    logic count_tick;

    at_lite_tick #(
        .PERIOD(LITE_PERIOD)
    ) u_lite (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(!power_mode[PM_HALT]),
        .tick(lite_tick)
    );

    // halt always stops; active-halt unless lite and ovf irq
    assign halted = power_mode[PM_HALT] || (power_mode[PM_ACTIVE_HALT] &&
        !(clock_select == CLK_LITE && overflow_irq_enable));

    always_comb begin
        case (clock_select)
            CLK_LITE: src_tick = lite_tick;
            CLK_CPU: src_tick = 1'b1;
            default: src_tick = 1'b0;
        endcase
    end

    logic slow_tick;

    at_tick_divider #(
        .DIVIDE(SLOW_DIVIDE)
    ) u_slow (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick_in(src_tick && !halted),
        .tick_out(slow_tick)
    );

    assign count_tick = !halted &&
        (power_mode[PM_SLOW] ? slow_tick : src_tick);

    // ------------------------------------------------------------------
    // counter, shadow, flags
    // ------------------------------------------------------------------
    logic [11:0] up_counter;
    logic wrap;
    logic [11:0] match_ref;
    logic match;
    logic at_match;
    logic overflow_flag;
    logic compare_flag;
    logic [3:0] high_latch;

    assign wrap = count_tick && (up_counter == COUNT_TOP);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_counter <= COUNT_RESET;
        end else if (count_tick) begin
            up_counter <= wrap ? reload_value : up_counter + 12'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shadow <= COUNT_RESET;
        end else if (wrap) begin
            shadow <= duty_compare_value;
        end
    end

    assign match_ref = pwm_pin_enable ? shadow : duty_compare_value;
    assign at_match = !compare_locked &&
        (match_ref != COUNT_RESET) && (up_counter == match_ref);
    assign match = count_tick && at_match;

    // set on wrap, next count tick or read clears; set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (count_tick ||
                     (rd_now && rd_idx == IDX_TIMER_CONTROL_STATUS)) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_flag <= 1'b0;
        end else if (match) begin
            compare_flag <= 1'b1;
        end else if (rd_now && rd_idx == IDX_PWM_CHANNEL_STATUS) begin
            compare_flag <= 1'b0;
        end
    end

    // latch upper bits on low read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_latch <= 4'h0;
        end else if (rd_now && rd_idx == IDX_COUNTER_LOW) begin
            high_latch <= up_counter[11:8];
        end
    end

    // ------------------------------------------------------------------
    // pwm output and interrupts
    // ------------------------------------------------------------------
    logic pwm_level;

    // high on overflow, low on match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_level <= 1'b0;
        end else if (wrap) begin
            pwm_level <= 1'b1;
        end else if (match && pwm_pin_enable) begin
            pwm_level <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_output_pin <= 1'b0;
        end else begin
            // inactive already while the counter sits on the match value: low, or high with output_polarity set
            pwm_output_pin <= pwm_pin_enable &&
                ((pwm_level && !at_match) ^ output_polarity);
        end
    end

    assign pwm_pin_oe = pwm_pin_enable;

    assign overflow_irq = overflow_flag && overflow_irq_enable;
    assign compare_irq = compare_flag && compare_irq_enable;

    assign wake_request = !power_mode[PM_HALT] &&
        ((power_mode[PM_WAIT] && (overflow_irq || compare_irq)) ||
         (power_mode[PM_ACTIVE_HALT] && overflow_irq &&
          clock_select == CLK_LITE));

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (rd_idx == IDX_TIMER_CONTROL_STATUS) begin
            rd_byte = {3'b000, clock_select, overflow_flag,
                       overflow_irq_enable, compare_irq_enable};
        end else if (rd_idx == IDX_COUNTER_HIGH) begin
            rd_byte = {4'h0, high_latch};
        end else if (rd_idx == IDX_COUNTER_LOW) begin
            rd_byte = up_counter[7:0];
        end else if (rd_idx == IDX_RELOAD_HIGH) begin
            rd_byte = {4'h0, reload_value[11:8]};
        end else if (rd_idx == IDX_RELOAD_LOW) begin
            rd_byte = reload_value[7:0];
        end else if (rd_idx == IDX_PWM_OUTPUT_CONTROL) begin
            rd_byte = {7'h00, pwm_pin_enable};
        end else if (rd_idx == IDX_PWM_CHANNEL_STATUS) begin
            rd_byte = {6'h00, output_polarity, compare_flag};
        end else if (rd_idx == IDX_DUTY_COMPARE_HIGH) begin
            rd_byte = {4'h0, duty_compare_value[11:8]};
        end else if (rd_idx == IDX_DUTY_COMPARE_LOW) begin
            rd_byte = duty_compare_value[7:0];
        end else if (rd_idx == IDX_POWER_MODE) begin
            rd_byte = {4'h0, power_mode};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_now) begin
            hrdata <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_zero_no_match;
        @(posedge hclk) disable iff (!hresetn)
        (match_ref == COUNT_RESET) |-> !match;
    endproperty
    a_zero_no_match: assert property (p_zero_no_match)
        else $error("compare matched a zero value");

    property p_wrap_reload;
        @(posedge hclk) disable iff (!hresetn)
        wrap |=> (up_counter == $past(reload_value));
    endproperty
    a_wrap_reload: assert property (p_wrap_reload)
        else $error("counter did not reload on wrap");

    property p_ovf_set;
        @(posedge hclk) disable iff (!hresetn)
        wrap |=> overflow_flag;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set on wrap");

    property p_shadow_copy;
        @(posedge hclk) disable iff (!hresetn)
        wrap |=> (shadow == $past(duty_compare_value));
    endproperty
    a_shadow_copy: assert property (p_shadow_copy)
        else $error("shadow not updated on overflow");

    property p_locked;
        @(posedge hclk) disable iff (!hresetn)
        compare_locked |-> !match;
    endproperty
    a_locked: assert property (p_locked)
        else $error("match while compare locked");

    property p_cmp_set;
        @(posedge hclk) disable iff (!hresetn)
        match |=> compare_flag;
    endproperty
    a_cmp_set: assert property (p_cmp_set)
        else $error("compare flag not set on match");

    property p_halt_stop;
        @(posedge hclk) disable iff (!hresetn)
        power_mode[PM_HALT] |=> $stable(up_counter);
    endproperty
    a_halt_stop: assert property (p_halt_stop)
        else $error("counter moved in halt");

    property p_pin_off;
        @(posedge hclk) disable iff (!hresetn)
        !pwm_pin_enable ##1 !pwm_pin_enable |-> !pwm_output_pin;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("pwm pin driven while disabled");

    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
        overflow_irq |-> overflow_irq_enable && overflow_flag;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("overflow irq without enable");

endmodule // autoreload_timer_pwm_compare

// *** tb.sv ***
// testbench: register map, counting, flags, compare, pwm and power modes
// assumes: design files compiled first; the slave answers with zero waits
`timescale 1ns/1ps
module tb;
    import at_timer_pkg::*;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic pwm_output_pin;
    logic pwm_pin_oe;
    logic overflow_irq;
    logic compare_irq;
    logic wake_request;
    logic [31:0] rdat;
    int n_mismatch = 0;
    int n_tests = 0;

    autoreload_timer_pwm_compare #(.LITE_PERIOD(20)) DUT (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hready),
        .hresp(hresp),
        .pwm_output_pin(pwm_output_pin),
        .pwm_pin_oe(pwm_pin_oe),
        .overflow_irq(overflow_irq),
        .compare_irq(compare_irq),
        .wake_request(wake_request)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic bus(input logic [7:0] idx, input logic w,
                       input logic [7:0] d);
        int k;
        k = 0;
        @(posedge hclk);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'b00};
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        rdat = hrdata;
        if (k >= 50) begin
            n_mismatch++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                      input string m);
        bus(idx, 1'b0, 8'h00);
        chk(rdat, {24'h0, e}, m);
    endtask

    // cycles to next overflow rise, and cycles the request stood high
    task automatic wait_rise(input int lim, output int n, output int hi);
        logic prev;
        prev = 1'b1;
        n = 0;
        hi = 0;
        forever begin
            @(negedge hclk);
            n++;
            if (overflow_irq === 1'b1) hi++;
            if ((overflow_irq === 1'b1 && prev === 1'b0) || n >= lim) break;
            prev = overflow_irq;
        end
        if (n >= lim) begin
            n_mismatch++;
            print_verdict();
        end
    endtask

    task automatic count_hi(input int len, output int c);
        c = 0;
        // skip the cycle in which the pin register still holds old state
        @(negedge hclk);
        repeat (len) begin
            @(negedge hclk);
            if (pwm_output_pin === 1'b1) c++;
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        logic [7:0] ridx [10];
        ridx = '{IDX_TIMER_CONTROL_STATUS, IDX_COUNTER_HIGH, IDX_COUNTER_LOW,
                 IDX_RELOAD_HIGH, IDX_RELOAD_LOW, IDX_PWM_OUTPUT_CONTROL,
                 IDX_PWM_CHANNEL_STATUS, IDX_DUTY_COMPARE_HIGH,
                 IDX_DUTY_COMPARE_LOW, IDX_POWER_MODE};
        foreach (ridx[i]) rd(ridx[i], REG_RESET, "reset value");
        chk(overflow_irq | compare_irq, 1'b0, "irq at reset");
        chk(pwm_pin_oe, 1'b0, "pin enable at reset");
        chk(hresp, 1'b0, "okay response");
        wr(IDX_COUNTER_LOW, 8'h55);
        rd(IDX_COUNTER_LOW, 8'h00, "counter write");
        wr(8'h14, 8'haa);
        rd(8'h14, 8'h00, "unmapped");
        $display("test reset done");
    endtask

    task automatic test_cpu();
        int n;
        int hi;
        wr(IDX_RELOAD_HIGH, 8'h0f);
        wr(IDX_RELOAD_LOW, 8'hf0);
        rd(IDX_RELOAD_LOW, 8'hf0, "reload rw");
        wr(IDX_TIMER_CONTROL_STATUS, 8'h12);
        wait_rise(5000, n, hi);
        wait_rise(100, n, hi);
        chk(n, 16, "reload period");
        chk(hi, 1, "overflow width");
        bus(IDX_COUNTER_LOW, 1'b0, 8'h00);
        chk(rdat[7:4], 4'hf, "counter low");
        rd(IDX_COUNTER_HIGH, 8'h0f, "counter high");
        $display("test cpu clock done");
    endtask

    task automatic test_lite();
        int n;
        int hi;
        wr(IDX_TIMER_CONTROL_STATUS, 8'h0a);
        wait_rise(400, n, hi);
        wait_rise(400, n, hi);
        chk(n, 320, "lite period");
        chk(hi, 20, "overflow width");
        wait_rise(400, n, hi);
        rd(IDX_TIMER_CONTROL_STATUS, 8'h0e, "overflow set");
        @(negedge hclk);
        chk(overflow_irq, 1'b0, "read clears");
        wr(IDX_TIMER_CONTROL_STATUS, 8'h08);
        hi = 0;
        repeat (400) begin
            @(negedge hclk);
            if (overflow_irq !== 1'b0) hi++;
        end
        chk(hi, 0, "masked overflow");
        $display("test lite clock done");
    endtask

    task automatic test_compare();
        wr(IDX_TIMER_CONTROL_STATUS, 8'h11);
        wr(IDX_DUTY_COMPARE_HIGH, 8'h0f);
        wr(IDX_DUTY_COMPARE_LOW, 8'hf8);
        repeat (20) @(negedge hclk);
        chk(compare_irq, 1'b1, "compare irq");
        // lock first so no fresh match lands between read and check
        wr(IDX_DUTY_COMPARE_HIGH, 8'h0f);
        rd(IDX_PWM_CHANNEL_STATUS, 8'h01, "compare flag");
        rd(IDX_PWM_CHANNEL_STATUS, 8'h00, "flag cleared");
        repeat (40) @(negedge hclk);
        rd(IDX_PWM_CHANNEL_STATUS, 8'h00, "locked");
        wr(IDX_DUTY_COMPARE_LOW, 8'hf8);
        repeat (40) @(negedge hclk);
        rd(IDX_PWM_CHANNEL_STATUS, 8'h01, "unlocked");
        wr(IDX_DUTY_COMPARE_HIGH, 8'h00);
        wr(IDX_DUTY_COMPARE_LOW, 8'h00);
        wr(IDX_RELOAD_HIGH, 8'h00);
        wr(IDX_RELOAD_LOW, 8'h00);
        // a match may land before the lock; drop it
        bus(IDX_PWM_CHANNEL_STATUS, 1'b0, 8'h00);
        rd(IDX_PWM_CHANNEL_STATUS, 8'h00, "flag cleared");
        repeat (4200) @(negedge hclk);
        rd(IDX_PWM_CHANNEL_STATUS, 8'h00, "zero compare");
        wr(IDX_RELOAD_HIGH, 8'h0f);
        wr(IDX_RELOAD_LOW, 8'hf0);
        $display("test compare done");
    endtask

    task automatic test_pwm();
        int n;
        int hi;
        int c;
        wr(IDX_TIMER_CONTROL_STATUS, 8'h12);
        wr(IDX_DUTY_COMPARE_HIGH, 8'h0f);
        wr(IDX_DUTY_COMPARE_LOW, 8'hfc);
        wr(IDX_PWM_OUTPUT_CONTROL, 8'h01);
        @(negedge hclk);
        chk(pwm_pin_oe, 1'b1, "pin enabled");
        wait_rise(5000, n, hi);
        wait_rise(100, n, hi);
        count_hi(64, c);
        chk(c, 48, "duty high count");
        wr(IDX_PWM_CHANNEL_STATUS, 8'h02);
        count_hi(64, c);
        chk(c, 16, "inverted count");
        rd(IDX_PWM_CHANNEL_STATUS, 8'h03, "polarity and flag");
        wr(IDX_PWM_CHANNEL_STATUS, 8'h00);
        wr(IDX_DUTY_COMPARE_HIGH, 8'h0e);
        wait_rise(100, n, hi);
        wait_rise(100, n, hi);
        count_hi(64, c);
        chk(c, 64, "shadow old low");
        chk(DUT.shadow, 32'h0000_0efc, "shadow new high old low");
        wr(IDX_PWM_OUTPUT_CONTROL, 8'h00);
        repeat (2) @(negedge hclk);
        chk({pwm_pin_oe, pwm_output_pin}, 2'b00, "pin released");
        $display("test pwm done");
    endtask

    task automatic test_power();
        int n;
        int hi;
        logic [7:0] first;
        logic [7:0] modes [2];
        modes = '{8'h08, 8'h04};
        foreach (modes[i]) begin
            wr(IDX_POWER_MODE, modes[i]);
            bus(IDX_COUNTER_LOW, 1'b0, 8'h00);
            first = rdat[7:0];
            repeat (21) @(negedge hclk);
            rd(IDX_COUNTER_LOW, first, "halted");
            chk(wake_request, 1'b0, "no wake while halted");
        end
        wr(IDX_POWER_MODE, 8'h02);
        wait_rise(100, n, hi);
        chk(wake_request, 1'b1, "overflow wakes from wait");
        wait_rise(100, n, hi);
        chk(n, 16, "wait mode period");
        wr(IDX_POWER_MODE, 8'h01);
        wait_rise(1200, n, hi);
        wait_rise(600, n, hi);
        chk(n, 512, "slow period");
        chk(hi, 32, "slow overflow width");
        $display("test power modes done");
    endtask

    // ------------------------------------------------------------------
    // clock, reset and main sequence
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset();
        test_cpu();
        test_lite();
        test_compare();
        test_pwm();
        test_power();
        print_verdict();
    end
endmodule // tb
